// [design/nvm_target.sv]
// Device end: memory controller reached over the programming link
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ns
// What this block does
// - Section erase plus code high byte erases code
// - Code write takes four low-then-high word pairs
// - Programmer sends idle between words of group
// - Fourth word high byte starts flash write
// - Section erase plus config high byte erases config
// - Config word written as four-word group too
// - Lock byte reads back at its mapped location
// - Lock low byte value, high byte starts write
// - No internal write or erase path exists
// - Link reaches command, status and data space
// - Programmer sends key, polls enabled flag
// - Programmer disables programming before releasing reset
// - Command field bits 5:0, bits 7:6 zero
// - Codes: none, chip erase, section erase, write
// - Status bit 7 busy during any operation
// - Status bits 6:0 read zero
// - Command writes ignored while busy
// - Busy blocks other programming and data space reads
// - Address bit 0 selects low or high byte
module nvm_target
  import nvm_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  nvm_link_if.target link,
  output logic       nvm_busy_flag,
  output logic       programming_enabled_flag,
  output logic [7:0] lock_bits
);
  typedef enum {ST_IDLE, ST_BUSY} state_t;
  typedef enum {OP_NONE, OP_CHIP, OP_ERASE_CODE, OP_ERASE_CFG,
                OP_WRITE_CODE, OP_WRITE_CFG, OP_WRITE_LOCK} op_t;

  logic [15:0] code_mem [CODE_WORDS];
  logic [15:0] cfg_mem  [CFG_WORDS];
  logic [15:0] buf_q    [GROUP_WORDS];
  logic [10:0] wadr_q   [GROUP_WORDS];

  state_t      state_q;
  op_t         op_q;
  logic [5:0]  cmd_q;
  logic [7:0]  lo_q;
  logic [7:0]  lock_lo_q;
  logic [1:0]  grp_q;
  logic [63:0] key_q;
  logic        start_q;
  logic        op_done;
  logic [7:0]  rdata_d;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire         busy       = (state_q == ST_BUSY);
  wire         hi_byte    = link.addr[0];
  wire         is_code    = (link.addr[15:12] == CODE_BASE_NIB);
  wire         is_cfg     = (link.addr[15:3] == CFG_BASE_HI);
  wire         is_lock    = (link.addr[15:1] == LOCK_WORD_HI);
  wire [10:0]  code_idx   = link.addr[11:1];
  wire [1:0]   cfg_idx    = link.addr[2:1];
  wire         cmd_wr     = link.req && (link.kind == LK_IO_WR) && programming_enabled_flag
                            && (link.addr == IO_CMD_ADDR) && !busy;
  wire         ds_wr      = link.req && (link.kind == LK_DS_WR) && programming_enabled_flag
                            && !busy;
  wire         ds_rd_ok   = programming_enabled_flag && !busy;
  wire         key_stb    = link.req && (link.kind == LK_KEY);
  wire [63:0]  key_d      = {key_q[55:0], link.wdata};
  wire         is_chip    = (cmd_q == CMD_CHIP_ERASE);
  wire         is_erase   = (cmd_q == CMD_SECT_ERASE);
  wire         is_write   = (cmd_q == CMD_CODE_WRITE);
  wire [15:0]  code_word  = code_mem[code_idx];
  wire [15:0]  cfg_word   = cfg_mem[cfg_idx];
  wire [15:0]  new_word   = {link.wdata, lo_q};
  wire         erase_op   = (op_q == OP_CHIP) || (op_q == OP_ERASE_CODE)
                            || (op_q == OP_ERASE_CFG);
  wire [TIMER_W-1:0] op_len = erase_op ? ERASE_CYCLES : WRITE_CYCLES;

  // I/O space and data space reads; no internal processor port is modelled at all
  always_comb
  begin
    rdata_d = ZERO_BYTE;
    if (link.kind == LK_IO_RD)
    begin
      if (link.addr == IO_CSR_ADDR)
        rdata_d = {busy, 7'h00};
      else if (link.addr == IO_CMD_ADDR)
        rdata_d = {2'b00, cmd_q};
    end
    else if (link.kind == LK_DS_RD && ds_rd_ok)
    begin
      if (is_code)
        rdata_d = hi_byte ? code_word[15:8] : code_word[7:0];
      else if (is_cfg)
        rdata_d = hi_byte ? cfg_word[15:8] : cfg_word[7:0];
      else if (is_lock && !hi_byte)
        rdata_d = lock_bits;
    end
  end

  nvm_busy_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (start_q),
    .load    (op_len),
    .done    (op_done)
  );

  // ---------------------------------------------------------------
  // Link answer, enable flag and command register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.rsp                 <= 1'b0;
      link.rdata               <= ZERO_BYTE;
      link.enabled             <= 1'b0;
      programming_enabled_flag <= 1'b0;
      key_q                    <= '0;
      cmd_q                    <= CMD_NOP;
    end
    else
    begin
      link.rsp   <= link.req;
      link.rdata <= link.req ? rdata_d : ZERO_BYTE;
      if (key_stb)
        key_q <= key_d;
      // Key only opens programming while the reset pin is held low
      if (key_stb && key_d == NVM_KEY && !link.reset_n)
      begin
        programming_enabled_flag <= 1'b1;
        link.enabled             <= 1'b1;
      end
      else if (link.req && link.kind == LK_DISABLE)
      begin
        programming_enabled_flag <= 1'b0;
        link.enabled             <= 1'b0;
      end
      if (cmd_wr)
        cmd_q <= link.wdata[5:0];
    end
  end

  // ---------------------------------------------------------------
  // Operation start and busy tracking
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q       <= ST_IDLE;
      op_q          <= OP_NONE;
      nvm_busy_flag <= 1'b0;
      start_q       <= 1'b0;
      lo_q          <= ZERO_BYTE;
      lock_lo_q     <= ERASED_BYTE;
      grp_q         <= 2'h0;
      lock_bits     <= ERASED_BYTE;
    end
    else
    begin
      start_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (ds_wr && hi_byte && (is_chip || is_erase) && (is_code || is_cfg))
          begin
            op_q          <= is_chip ? OP_CHIP : (is_code ? OP_ERASE_CODE : OP_ERASE_CFG);
            state_q       <= (is_chip && !is_code) ? ST_IDLE : ST_BUSY;
            nvm_busy_flag <= !(is_chip && !is_code);
            start_q       <= !(is_chip && !is_code);
          end
          else if (ds_wr && is_write && is_lock)
          begin
            if (!hi_byte)
              lock_lo_q <= link.wdata;
            else
            begin
              op_q          <= OP_WRITE_LOCK;
              state_q       <= ST_BUSY;
              nvm_busy_flag <= 1'b1;
              start_q       <= 1'b1;
            end
          end
          else if (ds_wr && is_write && (is_code || is_cfg))
          begin
            if (!hi_byte)
              lo_q <= link.wdata;
            else
            begin
              buf_q[grp_q]  <= new_word;
              wadr_q[grp_q] <= is_code ? code_idx : {9'h000, cfg_idx};
              grp_q         <= grp_q + 2'h1;
              if (grp_q == 2'(GROUP_WORDS - 1))
              begin
                op_q          <= is_code ? OP_WRITE_CODE : OP_WRITE_CFG;
                state_q       <= ST_BUSY;
                nvm_busy_flag <= 1'b1;
                start_q       <= 1'b1;
              end
            end
          end
          // Other codes reach no branch above and start nothing
        end
        ST_BUSY:
        begin
          if (op_done)
          begin
            state_q       <= ST_IDLE;
            nvm_busy_flag <= 1'b0;
            if (op_q == OP_CHIP)
              lock_bits <= ERASED_BYTE;
            else if (op_q == OP_WRITE_LOCK)
              lock_bits <= lock_bits & lock_lo_q;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Memory update at the end of an operation
  // ---------------------------------------------------------------
  // Flash cells only clear bits, so a write ANDs into the old content
  always_ff @(posedge pclk)
  begin
    if (busy && op_done)
    begin
      if (op_q == OP_CHIP || op_q == OP_ERASE_CODE)
        for (int i = 0; i < CODE_WORDS; i++)
          code_mem[i] <= ERASED_WORD;
      else if (op_q == OP_ERASE_CFG)
        for (int i = 0; i < CFG_WORDS; i++)
          cfg_mem[i] <= ERASED_WORD;
      else if (op_q == OP_WRITE_CODE)
        for (int i = 0; i < GROUP_WORDS; i++)
          code_mem[wadr_q[i]] <= code_mem[wadr_q[i]] & buf_q[i];
      else if (op_q == OP_WRITE_CFG)
        cfg_mem[wadr_q[0][1:0]] <= cfg_mem[wadr_q[0][1:0]] & buf_q[0];
    end
  end
endmodule : nvm_target

// [design/nvm_pkg.sv]
// Shared constants, types and link encodings for the programming sequencer
package nvm_pkg;

  // ---------------------------------------------------------------
  // Link transaction kinds
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LK_IO_RD,
    LK_IO_WR,
    LK_DS_RD,
    LK_DS_WR,
    LK_IDLE,
    LK_KEY,
    LK_DISABLE
  } link_kind_t;

  // ---------------------------------------------------------------
  // Device I/O space and data space map
  // ---------------------------------------------------------------
  localparam logic [15:0] IO_CSR_ADDR    = 16'h0032;
  localparam logic [15:0] IO_CMD_ADDR    = 16'h0033;
  localparam logic [3:0]  CODE_BASE_NIB  = 4'h4;
  localparam logic [12:0] CFG_BASE_HI    = 13'h07e8;
  localparam logic [14:0] LOCK_WORD_HI   = 15'h1f80;
  localparam int          CODE_WORDS     = 2048;
  localparam int          CFG_WORDS      = 4;
  localparam int          GROUP_WORDS    = 4;

  // ---------------------------------------------------------------
  // Command codes and register fields
  // ---------------------------------------------------------------
  localparam logic [5:0]  CMD_NOP        = 6'h00;
  localparam logic [5:0]  CMD_CHIP_ERASE = 6'h10;
  localparam logic [5:0]  CMD_SECT_ERASE = 6'h14;
  localparam logic [5:0]  CMD_CODE_WRITE = 6'h1d;
  localparam int          BUSY_BIT       = 7;
  localparam logic [15:0] ERASED_WORD    = 16'hffff;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;
  // Access key, value is arbitrary
  localparam logic [63:0] NVM_KEY        = 64'h5a3c_96e1_0f78_c2b4;

  // ---------------------------------------------------------------
  // Operation timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int ERASE_TIME_NS   = 20000;
  localparam int WRITE_TIME_NS   = 5000;
  localparam int TIMER_W         = 12;
  localparam logic [TIMER_W-1:0] ERASE_CYCLES =
    TIMER_W'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] WRITE_CYCLES =
    TIMER_W'((WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // Programmer-side APB register map
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_LINK_CMD   = 12'h000;
  localparam logic [11:0] REG_LINK_ADDR  = 12'h004;
  localparam logic [11:0] REG_STATUS     = 12'h008;
  localparam logic [11:0] REG_PIN        = 12'h00c;
  localparam int          CMD_KIND_LSB   = 8;
  localparam int          ST_PEND_BIT    = 0;
  localparam int          ST_EN_BIT      = 1;
  localparam int          ST_DATA_LSB    = 8;

endpackage : nvm_pkg

// [design/nvm_link_if.sv]
// Programming link between the external programmer and the device
`timescale 1ns/1ns
interface nvm_link_if;
  import nvm_pkg::*;
  logic             req;
  link_kind_t       kind;
  logic [15:0]      addr;
  logic [7:0]       wdata;
  logic             reset_n;
  logic             rsp;
  logic [7:0]       rdata;
  logic             enabled;

  modport programmer (output req, kind, addr, wdata, reset_n, input rsp, rdata, enabled);
  modport target     (input req, kind, addr, wdata, reset_n, output rsp, rdata, enabled);
endinterface : nvm_link_if

// [design/nvm_busy_timer.sv]
// Down counter that times one program or erase operation
`timescale 1ns/1ns
module nvm_busy_timer
  import nvm_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               start,
  input  wire logic [TIMER_W-1:0] load,
  output logic                    done
);
  logic [TIMER_W-1:0] cnt_q;
  logic               run_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      done <= run_q && (cnt_q == TIMER_W'(1));
      if (start)
      begin
        cnt_q <= load;
        run_q <= 1'b1;
      end
      else if (run_q)
      begin
        cnt_q <= cnt_q - TIMER_W'(1);
        run_q <= (cnt_q != TIMER_W'(1));
      end
    end
  end
endmodule : nvm_busy_timer

// [design/nvm_programmer.sv]
// Programmer end: APB-driven link master toward the device
`timescale 1ns/1ns
module nvm_programmer
  import nvm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  nvm_link_if.programmer   link
);
  logic       pend_q;
  logic [7:0] rd_q;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire acc_first = psel && penable && !pready;
  wire commit    = psel && penable && pready && pwrite && !pslverr;
  wire sel_cmd   = (paddr == REG_LINK_CMD);
  wire sel_addr  = (paddr == REG_LINK_ADDR);
  wire sel_stat  = (paddr == REG_STATUS);
  wire sel_pin   = (paddr == REG_PIN);
  wire mapped    = sel_cmd || sel_addr || sel_stat || sel_pin;
  wire [31:0] status_w = {16'h0000, rd_q, 6'h00, link.enabled, pend_q};
  wire [31:0] rd_mux   = sel_addr ? {16'h0000, link.addr} :
                         sel_stat ? status_w :
                         sel_pin  ? {31'h0000_0000, link.reset_n} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc_first;
      pslverr <= acc_first && !mapped;
      prdata  <= (acc_first && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Link transactions
  // ---------------------------------------------------------------
  // Idle, key and disable steps are sequenced by software as kinds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.req     <= 1'b0;
      link.kind    <= LK_IDLE;
      link.addr    <= 16'h0000;
      link.wdata   <= ZERO_BYTE;
      link.reset_n <= 1'b0;
      pend_q       <= 1'b0;
      rd_q         <= ZERO_BYTE;
    end
    else
    begin
      link.req <= 1'b0;
      if (commit && sel_addr)
        link.addr <= pwdata[15:0];
      if (commit && sel_cmd && !pend_q)
      begin
        link.req   <= 1'b1;
        link.kind  <= link_kind_t'(pwdata[CMD_KIND_LSB+2:CMD_KIND_LSB]);
        link.wdata <= pwdata[7:0];
        pend_q     <= 1'b1;
      end
      else if (link.rsp)
      begin
        pend_q <= 1'b0;
        rd_q   <= link.rdata;
      end
      // Reset may be released only once programming is disabled
      if (commit && sel_pin && !(pwdata[0] && link.enabled))
        link.reset_n <= pwdata[0];
    end
  end
endmodule : nvm_programmer

// [verif/nvm_program_sequencer_chk.sv]
// Link-level assertions for the programming sequencer
`timescale 1ns/1ns
module nvm_program_sequencer_chk
  import nvm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        req,
  input wire link_kind_t  kind,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        reset_n,
  input wire logic        rsp,
  input wire logic [7:0]  rdata,
  input wire logic        enabled,
  input wire logic        nvm_busy_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Busy length in cycles; an erase lasts too long for a delay range
  logic [TIMER_W-1:0] busy_len_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_len_q <= '0;
    else if (nvm_busy_flag)
      busy_len_q <= busy_len_q + TIMER_W'(1);
    else
      busy_len_q <= '0;
  end

  AST_RSP_FOLLOWS_REQ: assert property (req |=> rsp)
    else $error("rsp missing after req");
  AST_RSP_HAS_CAUSE: assert property (rsp |-> $past(req))
    else $error("rsp without req");
  AST_RDATA_QUIET: assert property (!rsp |-> rdata == 8'h00)
    else $error("rdata not zero outside rsp");
  AST_CSR_LAYOUT: assert property (
    rsp && $past(kind == LK_IO_RD && addr == IO_CSR_ADDR)
    |-> rdata == {$past(nvm_busy_flag), 7'h00})
    else $error("status byte wrong");
  AST_CMD_RESERVED: assert property (
    rsp && $past(kind == LK_IO_RD && addr == IO_CMD_ADDR) |-> rdata[7:6] == 2'b00)
    else $error("command reserved bits set");
  AST_BUSY_BLOCKS_READ: assert property (
    rsp && $past(kind == LK_DS_RD && nvm_busy_flag) |-> rdata == 8'h00)
    else $error("memory read while busy");
  AST_BUSY_CAUSE: assert property (
    $rose(nvm_busy_flag) |-> $past(req && kind == LK_DS_WR && addr[0] && enabled))
    else $error("busy without high byte write");
  AST_BUSY_SPAN: assert property (
    $fell(nvm_busy_flag) |->
      (busy_len_q >= WRITE_CYCLES && busy_len_q <= WRITE_CYCLES + TIMER_W'(2))
      || (busy_len_q >= ERASE_CYCLES && busy_len_q <= ERASE_CYCLES + TIMER_W'(2)))
    else $error("busy span wrong");
  AST_KEY_NEEDS_RESET: assert property (
    $rose(enabled) |-> $past(!reset_n && req && kind == LK_KEY))
    else $error("enabled without key under reset");
endmodule : nvm_program_sequencer_chk

// [verif/nvm_program_sequencer_bench.sv]
// Self-checking bench driving the programmer end over APB, with the target on the link
`timescale 1ns/1ns
module nvm_program_sequencer_bench;
  import nvm_pkg::*;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        nvm_busy_flag;
  logic        programming_enabled_flag;
  logic [7:0]  lock_bits;
  int          mismatches;
  int          check_count;
  nvm_link_if  lnk();

  nvm_programmer nvm_programmer_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lnk));
  nvm_target nvm_target_i (.pclk(pclk), .presetn(presetn), .link(lnk),
    .nvm_busy_flag(nvm_busy_flag), .programming_enabled_flag(programming_enabled_flag),
    .lock_bits(lock_bits));
  nvm_program_sequencer_chk nvm_program_sequencer_chk_i (.pclk(pclk), .presetn(presetn),
    .req(lnk.req), .kind(lnk.kind), .addr(lnk.addr), .wdata(lnk.wdata), .reset_n(lnk.reset_n),
    .rsp(lnk.rsp), .rdata(lnk.rdata), .enabled(lnk.enabled), .nvm_busy_flag(nvm_busy_flag));

  always #5 pclk = ~pclk;

  task automatic complete_run;
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (exp !== got)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Entered just after an edge; returns one edge after releasing the bus
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    paddr  <= a;
    pwrite <= wr;
    pwdata <= d;
    psel   <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // One link transaction; the next may only go once pending has cleared
  task automatic link(input link_kind_t k, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] rd);
    logic [31:0] q;
    logic        e;
    apb(1'b1, REG_LINK_ADDR, {16'h0000, a}, q, e);
    apb(1'b1, REG_LINK_CMD, {21'h00_0000, k, d}, q, e);
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0000_0000, q, e);
    end
    while (q[ST_PEND_BIT] !== 1'b0);
    rd = q[ST_DATA_LSB +: 8];
  endtask : link

  task automatic rd_chk(input string what, input link_kind_t k, input logic [15:0] a,
                        input logic [7:0] exp);
    logic [7:0] r;
    link(k, a, 8'h00, r);
    chk(what, {24'h00_0000, exp}, {24'h00_0000, r});
  endtask : rd_chk

  task automatic ds_wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    link(LK_DS_WR, a, d, r);
  endtask : ds_wr

  task automatic cmd(input logic [5:0] c);
    logic [7:0] r;
    link(LK_IO_WR, IO_CMD_ADDR, {2'b00, c}, r);
  endtask : cmd

  task automatic wait_idle;
    logic [7:0] r;
    do
    begin
      link(LK_IO_RD, IO_CSR_ADDR, 8'h00, r);
    end
    while (r[BUSY_BIT] !== 1'b0);
  endtask : wait_idle

  // Four-word group, low byte then high byte, idle between words
  task automatic group(input logic [15:0] base, input logic [63:0] w);
    logic [7:0] r;
    cmd(CMD_CODE_WRITE);
    for (int i = 0; i < GROUP_WORDS; i++)
    begin
      ds_wr(base + 16'(2*i), w[16*i +: 8]);
      if (i == GROUP_WORDS - 1)
        rd_chk("busy_early", LK_IO_RD, IO_CSR_ADDR, 8'h00);
      ds_wr(base + 16'(2*i+1), w[16*i+8 +: 8]);
      if (i < GROUP_WORDS - 1)
        link(LK_IDLE, 16'h0000, 8'h00, r);
    end
    rd_chk("busy_write", LK_IO_RD, IO_CSR_ADDR, 8'h80);
    chk("busy_port", 32'h0000_0001, {31'h0000_0000, nvm_busy_flag});
    wait_idle();
  endtask : group

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_start;
    logic [31:0] q;
    logic        e;
    logic [7:0]  r;
    apb(1'b0, REG_STATUS, 32'h0000_0000, q, e);
    chk("status_reset", 32'h0000_0000, q);
    apb(1'b0, 12'h010, 32'h0000_0000, q, e);
    chk("unmapped_err", 32'h0000_0001, {31'h0000_0000, e});
    rd_chk("csr_idle", LK_IO_RD, IO_CSR_ADDR, 8'h00);
    for (int i = 7; i >= 0; i--)
      link(LK_KEY, 16'h0000, NVM_KEY[8*i +: 8], r);
    apb(1'b0, REG_STATUS, 32'h0000_0000, q, e);
    chk("enabled", 32'h0000_0001, {31'h0000_0000, q[ST_EN_BIT]});
    chk("enabled_port", 32'h0000_0001, {31'h0000_0000, programming_enabled_flag});
    // All ones, so the reserved bits must be dropped on the way in
    link(LK_IO_WR, IO_CMD_ADDR, 8'hff, r);
    rd_chk("cmd_rsvd", LK_IO_RD, IO_CMD_ADDR, 8'h3f);
    ds_wr(16'h4001, 8'h00);
    rd_chk("unknown_cmd", LK_IO_RD, IO_CSR_ADDR, 8'h00);
  endtask : t_start

  task automatic t_code;
    cmd(CMD_SECT_ERASE);
    ds_wr(16'h4001, 8'h00);
    rd_chk("busy_erase", LK_IO_RD, IO_CSR_ADDR, 8'h80);
    cmd(CMD_CODE_WRITE);
    rd_chk("cmd_held", LK_IO_RD, IO_CMD_ADDR, {2'b00, CMD_SECT_ERASE});
    rd_chk("read_blocked", LK_DS_RD, 16'h4000, 8'h00);
    wait_idle();
    rd_chk("code_erased", LK_DS_RD, 16'h4000, ERASED_BYTE);
    group(16'h4010, 64'hc313_c212_c111_c010);
    for (int i = 0; i < 8; i++)
      rd_chk("code_byte", LK_DS_RD, 16'h4010 + 16'(i), (i % 2) ? 8'hc0 + 8'(i/2) : 8'h10 + 8'(i/2));
  endtask : t_code

  task automatic t_cfg_lock;
    cmd(CMD_SECT_ERASE);
    ds_wr(16'h3f43, 8'h00);
    wait_idle();
    rd_chk("cfg_erased", LK_DS_RD, 16'h3f42, ERASED_BYTE);
    group(16'h3f40, 64'h0000_0000_0000_5aa5);
    rd_chk("cfg_low", LK_DS_RD, 16'h3f40, 8'ha5);
    rd_chk("cfg_high", LK_DS_RD, 16'h3f41, 8'h5a);
    rd_chk("cfg_dummy", LK_DS_RD, 16'h3f42, ERASED_BYTE);
    cmd(CMD_CODE_WRITE);
    ds_wr(16'h3f00, 8'hfc);
    ds_wr(16'h3f01, 8'h00);
    rd_chk("busy_lock", LK_IO_RD, IO_CSR_ADDR, 8'h80);
    wait_idle();
    rd_chk("lock_read", LK_DS_RD, 16'h3f00, 8'hfc);
    chk("lock_port", 32'h0000_00fc, {24'h00_0000, lock_bits});
  endtask : t_cfg_lock

  task automatic t_chip_exit;
    logic [31:0] q;
    logic        e;
    logic [7:0]  r;
    cmd(CMD_CHIP_ERASE);
    ds_wr(16'h4fff, 8'h00);
    rd_chk("busy_chip", LK_IO_RD, IO_CSR_ADDR, 8'h80);
    wait_idle();
    rd_chk("chip_code", LK_DS_RD, 16'h4010, ERASED_BYTE);
    rd_chk("chip_lock", LK_DS_RD, 16'h3f00, ERASED_BYTE);
    chk("lock_port_erased", 32'h0000_00ff, {24'h00_0000, lock_bits});
    apb(1'b1, REG_PIN, 32'h0000_0001, q, e);
    apb(1'b0, REG_PIN, 32'h0000_0000, q, e);
    chk("pin_held", 32'h0000_0000, q);
    link(LK_DISABLE, 16'h0000, 8'h00, r);
    apb(1'b0, REG_STATUS, 32'h0000_0000, q, e);
    chk("disabled", 32'h0000_0000, {31'h0000_0000, q[ST_EN_BIT]});
    chk("disabled_port", 32'h0000_0000, {31'h0000_0000, programming_enabled_flag});
    apb(1'b1, REG_PIN, 32'h0000_0001, q, e);
    apb(1'b0, REG_PIN, 32'h0000_0000, q, e);
    chk("pin_released", 32'h0000_0001, q);
  endtask : t_chip_exit

  initial
  begin
    mismatches = 0;
    check_count = 0;
    pclk = 1'b0;
    presetn = 1'b0;
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_start();
    t_code();
    t_cfg_lock();
    t_chip_exit();
    complete_run();
  end

  // Full run needs well under 20000 cycles
  initial
  begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    complete_run();
  end
endmodule : nvm_program_sequencer_bench
